// >>> design/vfx_cmd_collect.sv
// Purpose: gathers function code and parameter bytes into a command
// Assumes: code byte written first, then exactly the expected bytes
// Notes: a new code write abandons a partial command
`include "vfx_defines.svh"
module vfx_cmd_collect
  import vfx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // byte strobes
  input wire logic code_wr,
  input wire logic param_wr,
  input wire logic [7:0] wr_byte,
  // command out
  vfx_cmd_if.collector cmd
);

  vfx_parse_st_t st_q;
  vfx_parse_st_t st_d;

  function automatic logic [4:0] param_count(input logic [7:0] fc);
    logic [4:0] n;
    n = 5'h00;
    unique case (fc)
      `VFX_FC_ASYM: n = `VFX_NP_ASYM;
      `VFX_FC_FILL: n = `VFX_NP_FILL;
      `VFX_FC_DISP: n = `VFX_NP_DISP;
      `VFX_FC_STILL: n = `VFX_NP_STILL;
      `VFX_FC_MASK: n = `VFX_NP_MASK;
      `VFX_FC_LOFS: n = `VFX_NP_LOFS;
      `VFX_FC_CHART: n = `VFX_NP_CHART;
      `VFX_FC_WIPE: n = `VFX_NP_WIPE;
      `VFX_FC_FREEZE, `VFX_FC_NONINT, `VFX_FC_ALT, `VFX_FC_PIX: n = `VFX_NP_ONE;
      default: n = 5'h00;
    endcase
    return n;
  endfunction : param_count

  always_comb
  begin
    st_d = st_q;
    st_d.valid = 1'b0;
    if (code_wr)
    begin
      // unknown codes leave the collector idle
      st_d.code = wr_byte;
      st_d.need = param_count(wr_byte);
      st_d.idx = 5'h00;
      st_d.state = (param_count(wr_byte) == 5'h00) ? VFX_PS_IDLE : VFX_PS_COLLECT;
    end
    else if (param_wr)
    begin
      unique case (st_q.state)
        VFX_PS_IDLE:
        begin
          st_d.state = VFX_PS_IDLE;
        end
        VFX_PS_COLLECT:
        begin
          st_d.params[st_q.idx[3:0]] = wr_byte;
          st_d.idx = st_q.idx + 5'h01;
          if (st_q.idx + 5'h01 == st_q.need)
          begin
            st_d.valid = 1'b1;
            st_d.state = VFX_PS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cmd.valid = st_q.valid;
  assign cmd.code = st_q.code;
  assign cmd.params = st_q.params;

endmodule : vfx_cmd_collect

// >>> design/vfx_effects_decoder.sv
// Purpose: executes videowall effects and second-source commands
// Assumes: command bytes arrive over the register port; video inputs synchronous
// Notes: one pixel path time-shared by monitor index; drawing engine is outside
//
// The address map and strobed register access were chosen for this implementation.
`include "vfx_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module vfx_effects_decoder
  import vfx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // primary video
  input wire logic field_a_start,
  input wire logic [3:0] mon_idx,
  input wire logic [23:0] vid_rgb,
  output logic [23:0] pix_rgb,
  // second source timing
  input wire logic field_b_start,
  // storage status
  input wire logic font_present,
  // magnification and field controls
  output logic [3:0] h_mag,
  output logic [3:0] v_mag,
  output logic h_shift,
  output logic v_shift,
  output logic [1:0] freeze_mode,
  output logic still_en,
  output logic still_update,
  output logic noninterlaced,
  output logic [7:0] line_offset,
  // alignment chart
  output logic chart_start,
  output logic chart_field,
  output logic [3:0] chart_split,
  output logic chart_numbers,
  output logic [3:0] chart_label,
  // transition
  output logic [1:0] wipe_target,
  output logic [1:0] wipe_dir,
  output logic [7:0] wipe_pos,
  output logic wipe_active,
  // second-source store
  output logic b_store_we,
  output logic b_write_bank,
  output logic b_read_bank
);

  typedef struct packed {
    logic [3:0] h_mag;
    logic [3:0] v_mag;
    logic h_shift;
    logic v_shift;
    logic [15:0][23:0] fill_rgb;
    logic [15:0] fill_mode;
    logic [15:0] sel_mask;
    vfx_pix_mode_t pix_mode;
    logic [1:0] freeze;
    logic still_en;
    logic [7:0] still_ivl;
    logic [7:0] still_cnt;
    logic still_update;
    logic nonint;
    logic [3:0][7:0] lofs;
    logic [7:0] line_offset;
    logic chart_start;
    logic chart_field;
    logic [3:0] chart_split;
    logic chart_numbers;
    logic [3:0] chart_label;
    logic [1:0] wipe_tgt;
    logic [1:0] wipe_dir;
    logic [7:0] wipe_speed;
    logic [15:0] wipe_pos;
    logic wipe_active;
    logic alt_field;
    logic b_keep;
    logic b_we;
    logic b_wbank;
    logic b_done_bank;
    logic b_rbank;
    logic [23:0] pix;
    logic [7:0] rdata;
  } vfx_exec_st_t;

  vfx_exec_st_t st_q;
  vfx_exec_st_t st_d;

  vfx_cmd_if cmd_bus ();

  vfx_cmd_collect u_collect (
    .sys_clk(sys_clk),
    .srst(srst),
    .code_wr(reg_wr && reg_addr == `VFX_OFS_CODE),
    .param_wr(reg_wr && reg_addr == `VFX_OFS_PARAM),
    .wr_byte(reg_wdata),
    .cmd(cmd_bus.collector)
  );

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range

  // single-monitor addressing ignores the mask; broadcast obeys it
  function automatic logic mon_hit(input logic [7:0] mon, input logic [3:0] i,
                                   input logic [15:0] mask);
    if (mon == `VFX_ALL_MON)
    begin
      return mask[i];
    end
    return (mon[7:4] == 4'h0) && (mon[3:0] == i);
  endfunction : mon_hit

  function automatic logic [7:0] pix_fx(input vfx_pix_mode_t m, input logic [7:0] x);
    logic [7:0] y;
    y = x;
    unique case (m)
      VFX_PIX_NORMAL: y = x;
      VFX_PIX_TRUNC: y = x & `VFX_TRUNC_MASK;
      VFX_PIX_INVERT: y = ~x;
      VFX_PIX_HILITE: y = x[7] ? 8'hFF : {x[6:0], 1'b0};
      default: y = x;
    endcase
    return y;
  endfunction : pix_fx

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] p3;
  logic [7:0] p4;
  logic mask_ok;
  logic [3:0] split_now;
  logic [16:0] wipe_sum;

  always_comb
  begin
    p1 = cmd_bus.params[0];
    p2 = cmd_bus.params[1];
    p3 = cmd_bus.params[2];
    p4 = cmd_bus.params[3];
    mask_ok = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      if (cmd_bus.params[i][7:1] != 7'h00)
      begin
        mask_ok = 1'b0;
      end
    end
    split_now = st_q.v_mag;
    wipe_sum = {1'b0, st_q.wipe_pos} + {9'h000, st_q.wipe_speed};

    st_d = st_q;
    st_d.chart_start = 1'b0;
    st_d.still_update = 1'b0;

    if (cmd_bus.valid)
    begin
      unique case (cmd_bus.code)
        `VFX_FC_ASYM:
        begin
          if (in_range(p1, `VFX_MAG_MIN, `VFX_MAG_MAX)
              && in_range(p2, `VFX_MAG_MIN, `VFX_MAG_MAX))
          begin
            st_d.h_mag = p1[3:0];
            st_d.v_mag = p2[3:0];
            st_d.h_shift = 1'b0;
            st_d.v_shift = 1'b0;
          end
        end
        `VFX_FC_FILL:
        begin
          for (int i = 0; i < 16; i++)
          begin
            if (mon_hit(p1, i[3:0], st_q.sel_mask))
            begin
              st_d.fill_rgb[i] = {p2, p3, p4};
            end
          end
        end
        `VFX_FC_DISP:
        begin
          if (p2 <= 8'h01)
          begin
            for (int i = 0; i < 16; i++)
            begin
              if (mon_hit(p1, i[3:0], st_q.sel_mask))
              begin
                st_d.fill_mode[i] = p2[0];
              end
            end
          end
        end
        `VFX_FC_PIX:
        begin
          unique case (p1)
            8'h00: st_d.pix_mode = VFX_PIX_NORMAL;
            8'h01: st_d.pix_mode = VFX_PIX_TRUNC;
            8'h02: st_d.pix_mode = VFX_PIX_INVERT;
            8'h04: st_d.pix_mode = VFX_PIX_HILITE;
            default: st_d.pix_mode = st_q.pix_mode;
          endcase
        end
        `VFX_FC_FREEZE:
        begin
          if (p1 <= `VFX_FREEZE_MAX)
          begin
            st_d.freeze = p1[1:0];
          end
        end
        `VFX_FC_STILL:
        begin
          if (p1 <= 8'h01)
          begin
            st_d.still_en = p1[0];
            st_d.still_ivl = p2;
            st_d.still_cnt = 8'h00;
          end
        end
        `VFX_FC_NONINT:
        begin
          if (p1 <= 8'h01)
          begin
            st_d.nonint = p1[0];
          end
        end
        `VFX_FC_LOFS:
        begin
          if (in_range(p1, 8'h01, `VFX_LOFS_SPLIT_MAX))
          begin
            st_d.lofs[p1[1:0] - 2'h1] = p2;
          end
        end
        `VFX_FC_MASK:
        begin
          if (mask_ok)
          begin
            for (int i = 0; i < 16; i++)
            begin
              st_d.sel_mask[i] = cmd_bus.params[i][0];
            end
          end
        end
        `VFX_FC_CHART:
        begin
          if (p1 <= 8'h01 && p2 <= `VFX_CHART_SPLIT_MAX)
          begin
            st_d.chart_start = 1'b1;
            st_d.chart_field = p1[0];
            st_d.chart_split = (p2 == 8'h00) ? split_now : p2[3:0];
            st_d.chart_numbers = font_present;
          end
        end
        `VFX_FC_WIPE:
        begin
          if (p1 <= `VFX_WIPE_TGT_MAX && p2 <= `VFX_WIPE_DIR_MAX && p3 != 8'h00)
          begin
            st_d.wipe_tgt = p1[1:0];
            st_d.wipe_dir = p2[1:0];
            st_d.wipe_speed = p3;
            st_d.wipe_pos = 16'h0000;
            st_d.wipe_active = 1'b1;
          end
        end
        `VFX_FC_ALT:
        begin
          if (p1 <= 8'h01)
          begin
            st_d.alt_field = p1[0];
          end
        end
        default:
        begin
          st_d.chart_start = 1'b0;
        end
      endcase
    end

    // primary field timing: still cadence and transition sweep
    if (field_a_start)
    begin
      if (st_q.still_en)
      begin
        if (st_q.still_cnt >= st_q.still_ivl)
        begin
          st_d.still_update = 1'b1;
          st_d.still_cnt = 8'h00;
        end
        else
        begin
          st_d.still_cnt = st_q.still_cnt + 8'h01;
        end
      end
      if (st_q.wipe_active)
      begin
        // saturate so a fast sweep lands exactly on its end
        st_d.wipe_pos = wipe_sum[16] ? `VFX_WIPE_END : wipe_sum[15:0];
        st_d.wipe_active = !(wipe_sum[16] || wipe_sum[15:0] == `VFX_WIPE_END);
      end
      // reader only ever switches to a completely written bank
      st_d.b_rbank = st_q.b_done_bank;
    end

    // second source store, paced by its own field starts
    if (field_b_start)
    begin
      if (st_q.b_we)
      begin
        st_d.b_done_bank = st_q.b_wbank;
        st_d.b_wbank = ~st_q.b_wbank;
      end
      st_d.b_keep = ~st_q.b_keep;
      st_d.b_we = !st_q.alt_field || st_q.b_keep;
    end

    // offset applies to the split in use; splits above four have none
    st_d.line_offset = in_range({4'h0, st_q.v_mag}, 8'h01, `VFX_LOFS_SPLIT_MAX)
                       ? st_q.lofs[st_q.v_mag[1:0] - 2'h1] : 8'h00;
    st_d.chart_label = {mon_idx[3:2], 2'b00} + {2'b00, mon_idx[1:0]};

    // fill colour reaches the screen only where fill is shown
    if (st_q.fill_mode[mon_idx])
    begin
      st_d.pix = st_q.fill_rgb[mon_idx];
    end
    else
    begin
      st_d.pix = {pix_fx(st_q.pix_mode, vid_rgb[23:16]),
                  pix_fx(st_q.pix_mode, vid_rgb[15:8]),
                  pix_fx(st_q.pix_mode, vid_rgb[7:0])};
    end

    // read data valid only in the cycle after the strobe
    st_d.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `VFX_OFS_STAT: st_d.rdata = {st_q.wipe_active, st_q.alt_field, st_q.nonint,
                                      st_q.still_en, st_q.h_shift, st_q.v_shift,
                                      st_q.freeze};
        `VFX_OFS_PIX: st_d.rdata = {5'h00, st_q.pix_mode};
        `VFX_OFS_MAG: st_d.rdata = {st_q.h_mag, st_q.v_mag};
        `VFX_OFS_MASK_LO: st_d.rdata = st_q.sel_mask[7:0];
        `VFX_OFS_MASK_HI: st_d.rdata = st_q.sel_mask[15:8];
        `VFX_OFS_WIPE: st_d.rdata = st_q.wipe_pos[15:8];
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q <= '0;
      st_q.h_mag <= `VFX_RST_MAG;
      st_q.v_mag <= `VFX_RST_MAG;
      st_q.sel_mask <= `VFX_RST_MASK;
      st_q.pix_mode <= VFX_PIX_NORMAL;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = st_q.rdata;
  assign pix_rgb = st_q.pix;
  assign h_mag = st_q.h_mag;
  assign v_mag = st_q.v_mag;
  assign h_shift = st_q.h_shift;
  assign v_shift = st_q.v_shift;
  assign freeze_mode = st_q.freeze;
  assign still_en = st_q.still_en;
  assign still_update = st_q.still_update;
  assign noninterlaced = st_q.nonint;
  assign line_offset = st_q.line_offset;
  assign chart_start = st_q.chart_start;
  assign chart_field = st_q.chart_field;
  assign chart_split = st_q.chart_split;
  assign chart_numbers = st_q.chart_numbers;
  assign chart_label = st_q.chart_label;
  assign wipe_target = st_q.wipe_tgt;
  assign wipe_dir = st_q.wipe_dir;
  assign wipe_pos = st_q.wipe_pos[15:8];
  assign wipe_active = st_q.wipe_active;
  assign b_store_we = st_q.b_we;
  assign b_write_bank = st_q.b_wbank;
  assign b_read_bank = st_q.b_rbank;

endmodule : vfx_effects_decoder

// >>> dv/vfx_effects_decoder_properties.sv
// Purpose: port-level properties of the effects decoder
// Assumes: bound to vfx_effects_decoder, one clock domain
// Notes: bind follows the module
module vfx_effects_decoder_properties
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // stimulus
  input wire logic field_a_start,
  input wire logic field_b_start,
  input wire logic font_present,
  input wire logic [3:0] mon_idx,
  // observed
  input wire logic [3:0] h_mag,
  input wire logic [3:0] v_mag,
  input wire logic h_shift,
  input wire logic v_shift,
  input wire logic still_en,
  input wire logic still_update,
  input wire logic chart_start,
  input wire logic [3:0] chart_split,
  input wire logic chart_numbers,
  input wire logic [3:0] chart_label,
  input wire logic [7:0] wipe_pos,
  input wire logic wipe_active,
  input wire logic b_store_we,
  input wire logic b_write_bank,
  input wire logic b_read_bank
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////
  a_mag_range:
    assert property (h_mag >= 4'h1 && h_mag <= 4'h8 && v_mag >= 4'h1 && v_mag <= 4'h8)
    else $error("magnification out of range");
  a_shift_clear:
    assert property (($changed(h_mag) || $changed(v_mag)) |-> !h_shift && !v_shift)
    else $error("shift set with new magnification");
  a_still_cause:
    assert property (still_update |-> $past(field_a_start) && $past(still_en) ##1 !still_update)
    else $error("still update without enabled field start");
  a_chart_font:
    assert property (chart_start |-> chart_numbers == $past(font_present))
    else $error("chart numbering does not follow font presence");
  a_chart_split:
    assert property (chart_start |-> chart_split != 4'h0)
    else $error("chart started with split zero");
  a_chart_label:
    assert property ($past(!srst) |-> chart_label == $past(mon_idx))
    else $error("channel label not the monitor position");
  a_bstore_steady:
    assert property ($past(!srst) && !$past(field_b_start)
      |-> $stable(b_store_we) && $stable(b_write_bank))
    else $error("second-source store changed between fields");
  a_read_bank:
    assert property ($changed(b_read_bank) |-> $past(field_a_start))
    else $error("read bank moved off primary field timing");
  a_wipe_end:
    assert property ($fell(wipe_active) |-> wipe_pos == 8'hFF)
    else $error("transition ended before full travel");
endmodule : vfx_effects_decoder_properties

bind vfx_effects_decoder vfx_effects_decoder_properties i_props (.sys_clk, .srst,
  .field_a_start, .field_b_start, .font_present, .mon_idx, .h_mag, .v_mag, .h_shift,
  .v_shift, .still_en, .still_update, .chart_start, .chart_split, .chart_numbers,
  .chart_label, .wipe_pos, .wipe_active, .b_store_we, .b_write_bank, .b_read_bank);

// >>> dv/vfx_effects_decoder_test.sv
// Purpose: self-checking bench of the effects decoder
// Assumes: commands sent through the host model
// Notes: video input held at one sample
`include "vfx_defines.svh"
module vfx_effects_decoder_test
  import vfx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr, mon_idx = 4'h0;
  logic [7:0] reg_wdata, reg_rdata, line_offset, wipe_pos, rv;
  logic reg_wr, reg_rd, field_a_start = 1'b0, field_b_start = 1'b0, font_present = 1'b1;
  logic [23:0] vid_rgb = 24'hC53A80;
  logic [23:0] pix_rgb;
  logic [3:0] h_mag, v_mag, chart_split, chart_label;
  logic h_shift, v_shift, still_en, still_update, noninterlaced, chart_start, chart_field;
  logic chart_numbers, wipe_active, b_store_we, b_write_bank, b_read_bank;
  logic [1:0] freeze_mode, wipe_target, wipe_dir;
  logic [7:0] pm [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03};
  logic [7:0] pr [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h04};
  logic [23:0] px [5] = '{24'hC53A80, 24'hC02080, 24'h3AC57F, 24'hFF74FF, 24'hFF74FF};
  vfx_params_t p;
  int bad_count = 0;
  int n_compared = 0;
  int n_still = 0;
  int n_chart = 0;
  int k;

  vfx_host_model i_host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  vfx_effects_decoder i_dut (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .field_a_start, .mon_idx, .vid_rgb, .pix_rgb, .field_b_start, .font_present,
    .h_mag, .v_mag, .h_shift, .v_shift, .freeze_mode, .still_en, .still_update,
    .noninterlaced, .line_offset, .chart_start, .chart_field, .chart_split, .chart_numbers,
    .chart_label, .wipe_target, .wipe_dir, .wipe_pos, .wipe_active, .b_store_we,
    .b_write_bank, .b_read_bank);

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (still_update === 1'b1)
      n_still++;
    if (chart_start === 1'b1)
      n_chart++;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic cmd(input logic [7:0] c, input int n, input logic [7:0] b1,
    input logic [7:0] b2 = 8'h00, input logic [7:0] b3 = 8'h00, input logic [7:0] b4 = 8'h00);
    vfx_params_t q;
    q = '0;
    q[0] = b1;
    q[1] = b2;
    q[2] = b3;
    q[3] = b4;
    i_host.send(c, n, q);
  endtask : cmd

  task automatic readchk(input logic [3:0] a, input logic [7:0] e);
    i_host.rd(a, rv);
    check(24'(rv), 24'(e));
  endtask : readchk

  task automatic look(input logic [3:0] m);
    mon_idx <= m;
    repeat (2) @(posedge sys_clk);
  endtask : look

  task automatic fields(input bit b, input int n);
    repeat (n)
    begin
      field_a_start <= !b;
      field_b_start <= b;
      @(posedge sys_clk);
      field_a_start <= 1'b0;
      field_b_start <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask : fields

  ////////////////////////////////////////////////////////////
  // longest stretch is the full-speed transition, 257 fields of 4 cycles, about 1030 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    readchk(`VFX_OFS_MASK_LO, 8'hFF);
    readchk(`VFX_OFS_MASK_HI, 8'hFF);
    readchk(`VFX_OFS_MAG, 8'h11);
    readchk(4'h9, 8'h00);
    cmd(`VFX_FC_ASYM, 2, 8'h04, 8'h02);
    check(24'({h_mag, v_mag, 2'b00, h_shift, v_shift}), 24'h420);
    cmd(`VFX_FC_ASYM, 2, 8'h09, 8'h01);
    cmd(`VFX_FC_ASYM, 2, 8'h00, 8'h03);
    check(24'({h_mag, v_mag}), 24'h42);
    cmd(`VFX_FC_ASYM, 2, 8'h08, 8'h01);
    check(24'({h_mag, v_mag}), 24'h81);
    cmd(`VFX_FC_ASYM, 2, 8'h01, 8'h02);
    readchk(`VFX_OFS_MAG, 8'h12);
    for (int i = 0; i < 5; i++)
    begin
      cmd(`VFX_FC_PIX, 1, pm[i]);
      readchk(`VFX_OFS_PIX, pr[i]);
      check(pix_rgb, px[i]);
    end
    cmd(`VFX_FC_PIX, 1, 8'h00);
    cmd(`VFX_FC_FILL, 4, 8'h02, 8'h10, 8'h20, 8'h30);
    look(4'h2);
    check(pix_rgb, vid_rgb);
    cmd(`VFX_FC_DISP, 2, 8'h02, 8'h01);
    check(pix_rgb, 24'h102030);
    cmd(`VFX_FC_FILL, 4, 8'h02, 8'h40, 8'h50, 8'h60);
    check(pix_rgb, 24'h405060);
    for (int i = 0; i < 16; i++)
      p[i] = (i == 2) ? 8'h00 : 8'h01;
    i_host.send(`VFX_FC_MASK, 16, p);
    readchk(`VFX_OFS_MASK_LO, 8'hFB);
    readchk(`VFX_OFS_MASK_HI, 8'hFF);
    cmd(`VFX_FC_FILL, 4, `VFX_ALL_MON, 8'hAA, 8'hBB, 8'hCC);
    cmd(`VFX_FC_DISP, 2, `VFX_ALL_MON, 8'h01);
    check(pix_rgb, 24'h405060);
    look(4'h3);
    check(pix_rgb, 24'hAABBCC);
    look(4'h2);
    cmd(`VFX_FC_FILL, 4, 8'h02, 8'h11, 8'h22, 8'h33);
    check(pix_rgb, 24'h112233);
    cmd(`VFX_FC_DISP, 2, 8'h02, 8'h00);
    check(pix_rgb, vid_rgb);
    p[5] = 8'h02;
    i_host.send(`VFX_FC_MASK, 16, p);
    readchk(`VFX_OFS_MASK_LO, 8'hFB);
    for (int i = 0; i < 5; i++)
    begin
      cmd(`VFX_FC_FREEZE, 1, 8'(i));
      check(24'(freeze_mode), 24'((i > 3) ? 3 : i));
    end
    readchk(`VFX_OFS_STAT, 8'h03);
    cmd(`VFX_FC_NONINT, 1, 8'h01);
    cmd(`VFX_FC_NONINT, 1, 8'h02);
    check(24'(noninterlaced), 24'h1);
    cmd(`VFX_FC_NONINT, 1, 8'h00);
    check(24'(noninterlaced), 24'h0);
    cmd(`VFX_FC_LOFS, 2, 8'h02, 8'hFD);
    check(24'(line_offset), 24'hFD);
    cmd(`VFX_FC_LOFS, 2, 8'h04, 8'h03);
    cmd(`VFX_FC_LOFS, 2, 8'h05, 8'h07);
    check(24'(line_offset), 24'hFD);
    cmd(`VFX_FC_ASYM, 2, 8'h01, 8'h04);
    check(24'(line_offset), 24'h03);
    cmd(`VFX_FC_CHART, 2, 8'h01, 8'h03);
    check(24'({chart_field, chart_split, chart_numbers}), 24'h27);
    font_present <= 1'b0;
    @(posedge sys_clk);
    cmd(`VFX_FC_CHART, 2, 8'h00, 8'h00);
    cmd(`VFX_FC_CHART, 2, 8'h00, 8'h05);
    check(24'({chart_field, chart_split, chart_numbers}), 24'h08);
    check(24'(n_chart), 24'h2);
    look(4'hB);
    check(24'(chart_label), 24'hB);
    cmd(`VFX_FC_STILL, 2, 8'h01, 8'h02);
    n_still = 0;
    fields(1'b0, 9);
    check(24'({still_en, 7'h0, 8'(n_still)}), 24'h8003);
    cmd(`VFX_FC_STILL, 2, 8'h00, 8'h00);
    n_still = 0;
    fields(1'b0, 4);
    check(24'({still_en, 7'h0, 8'(n_still)}), 24'h0000);
    for (int i = 0; i < 4; i++)
    begin
      cmd(`VFX_FC_WIPE, 3, 8'(i % 3), 8'(i), 8'hC8);
      check(24'({wipe_target, wipe_dir}), 24'((i % 3) * 4 + i));
    end
    cmd(`VFX_FC_WIPE, 3, 8'h02, 8'h01, 8'h00);
    check(24'({wipe_target, wipe_dir}), 24'h3);
    cmd(`VFX_FC_WIPE, 3, 8'h01, 8'h02, 8'hFF);
    k = 0;
    while (wipe_active === 1'b1 && k < 300)
    begin
      fields(1'b0, 1);
      k++;
    end
    check(24'(k), 24'd257);
    check(24'(wipe_pos), 24'hFF);
    readchk(`VFX_OFS_WIPE, 8'hFF);
    cmd(`VFX_FC_ALT, 1, 8'h00);
    fields(1'b1, 3);
    check(24'(b_store_we), 24'h1);
    fields(1'b0, 1);
    check(24'({b_read_bank, b_write_bank}), 24'h2);
    cmd(`VFX_FC_ALT, 1, 8'h01);
    k = 0;
    repeat (4)
    begin
      fields(1'b1, 1);
      k += int'(b_store_we === 1'b1);
    end
    check(24'(k), 24'h2);
    srst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check(24'({h_mag, v_mag}), 24'h11);
    readchk(`VFX_OFS_MASK_LO, 8'hFF);
    close_out();
  end
endmodule : vfx_effects_decoder_test

// >>> dv/vfx_host_model.sv
// Purpose: host sending function-code commands over the register port
// Assumes: tasks entered just after a rising clock edge
// Notes: write data shows inverted junk while the port is idle
`include "vfx_defines.svh"
module vfx_host_model
  import vfx_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // register port
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    reg_addr = 4'hF;
    reg_wdata = 8'h5A;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // strobe held across bytes so it is never lowered and raised in one step
  task automatic send(input logic [7:0] code, input int n, input vfx_params_t p);
    reg_addr <= `VFX_OFS_CODE;
    reg_wdata <= code;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < n; i++)
    begin
      reg_addr <= `VFX_OFS_PARAM;
      reg_wdata <= p[i];
      @(posedge sys_clk);
    end
    reg_wr <= 1'b0;
    reg_wdata <= ~reg_wdata;
    repeat (3) @(posedge sys_clk);
  endtask : send

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : rd
endmodule : vfx_host_model

// >>> pkg/vfx_cmd_if.sv
// Purpose: complete command from the byte collector to the executor
// Assumes: valid is a one-cycle pulse
// Notes: params[0] is parameter byte 1
interface vfx_cmd_if;
  import vfx_pkg::*;
  logic valid;
  logic [7:0] code;
  vfx_params_t params;
  modport collector (output valid, output code, output params);
  modport executor (input valid, input code, input params);
endinterface : vfx_cmd_if

// >>> pkg/vfx_defines.svh
// Purpose: constants of the videowall effects command decoder
// Assumes: included by its bare name from the modules
// Notes: definitions only
`ifndef VFX_DEFINES_SVH
`define VFX_DEFINES_SVH

// function codes
`define VFX_FC_ASYM 8'h64
`define VFX_FC_FILL 8'h29
`define VFX_FC_DISP 8'h2A
`define VFX_FC_FREEZE 8'h2C
`define VFX_FC_STILL 8'h2D
`define VFX_FC_NONINT 8'h2E
`define VFX_FC_MASK 8'h2F
`define VFX_FC_LOFS 8'h30
`define VFX_FC_CHART 8'h33
`define VFX_FC_WIPE 8'h34
`define VFX_FC_ALT 8'h37
`define VFX_FC_PIX 8'h60

// parameter byte counts
`define VFX_NP_ASYM 5'h02
`define VFX_NP_FILL 5'h04
`define VFX_NP_DISP 5'h02
`define VFX_NP_ONE 5'h01
`define VFX_NP_STILL 5'h02
`define VFX_NP_MASK 5'h10
`define VFX_NP_LOFS 5'h02
`define VFX_NP_CHART 5'h02
`define VFX_NP_WIPE 5'h03

// field values
`define VFX_ALL_MON 8'hFF
`define VFX_MAG_MIN 8'h01
`define VFX_MAG_MAX 8'h08
`define VFX_LOFS_SPLIT_MAX 8'h04
`define VFX_CHART_SPLIT_MAX 8'h04
`define VFX_FREEZE_MAX 8'h03
`define VFX_WIPE_TGT_MAX 8'h02
`define VFX_WIPE_DIR_MAX 8'h03
`define VFX_TRUNC_MASK 8'hE0
`define VFX_WIPE_END 16'hFFFF
`define VFX_CHART_COLS 4'h4

// register offsets
`define VFX_OFS_CODE 4'h0
`define VFX_OFS_PARAM 4'h1
`define VFX_OFS_STAT 4'h2
`define VFX_OFS_PIX 4'h3
`define VFX_OFS_MAG 4'h4
`define VFX_OFS_MASK_LO 4'h5
`define VFX_OFS_MASK_HI 4'h6
`define VFX_OFS_WIPE 4'h7

// reset values
`define VFX_RST_MASK 16'hFFFF
`define VFX_RST_MAG 4'h1

`endif

// >>> pkg/vfx_pkg.sv
// Purpose: types of the videowall effects command decoder
// Assumes: nothing
// Notes: constants live in vfx_defines.svh
package vfx_pkg;

  typedef enum logic [2:0] {
    VFX_PIX_NORMAL = 3'b000,
    VFX_PIX_TRUNC = 3'b001,
    VFX_PIX_INVERT = 3'b010,
    VFX_PIX_HILITE = 3'b100
  } vfx_pix_mode_t;

  typedef enum logic {
    VFX_PS_IDLE = 1'b0,
    VFX_PS_COLLECT = 1'b1
  } vfx_parse_state_t;

  typedef logic [15:0][7:0] vfx_params_t;

  typedef struct packed {
    vfx_parse_state_t state;
    logic [7:0] code;
    logic [4:0] need;
    logic [4:0] idx;
    vfx_params_t params;
    logic valid;
  } vfx_parse_st_t;

endpackage : vfx_pkg
